// file: src/sid_dispatch.sv
// script interrupt dispatch: command decode, accumulator/x register, vectors
// assumes commands arrive as one-cycle strobes from an interpreter on clock_i;
// event inputs are pins and are synchronised here
// Function
// - decode 14 write-output, 15 read-input, both modes
// - decode 19,33 arithmetic; 34,35,39 accumulator copies
// - program reads store result in accumulator
// - x register loadable from accumulator
// - direct reads answer host, accumulator untouched
// - host queries never disturb running program
// - decode 25 enable, 26 disable, 37 vector
// - one handler address per interrupt number
// - numbers: timers 0-2, reached 3-8, stall 15-20, deviation 21-26
// - stop switches 27-38 left/right, inputs 39-42
// - dispatch only if enabled and vector defined
// - save accumulator, x register, flags before handler
// - no interrupt entered during a handler
// - return command 38 restores context and resumes
// - bank 3 global parameter configures interrupt
// - number 255 gates all interrupts globally
`timescale 1ns/100ps
`default_nettype none
module sid_dispatch
   import sid_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_direct_i,
   input wire logic [7:0] cmd_num_i,
   input wire logic [7:0] cmd_type_i,
   input wire logic [7:0] cmd_bank_i,
   input wire logic [DATA_W-1:0] cmd_value_i,
   input wire logic [DATA_W-1:0] read_data_i,
   input wire logic [ADDR_W-1:0] pc_i,
   input wire logic [FLAG_W-1:0] flags_i,
   input wire logic [2:0] timer_evt_i,
   input wire logic [5:0] reached_evt_i,
   input wire logic [5:0] stall_evt_i,
   input wire logic [5:0] deviation_evt_i,
   input wire logic [11:0] stop_switch_evt_i,
   input wire logic [3:0] input_change_evt_i,
   output logic write_output_o,
   output logic read_input_o,
   output logic accu_to_axis_param_o,
   output logic accu_to_global_param_o,
   output logic accu_to_coord_o,
   output logic irq_config_o,
   output logic [IRQ_W-1:0] irq_config_num_o,
   output logic [DATA_W-1:0] irq_config_value_o,
   output logic [DATA_W-1:0] accu_o,
   output logic [DATA_W-1:0] xreg_o,
   output logic reply_valid_o,
   output logic [DATA_W-1:0] reply_data_o,
   output logic jump_o,
   output logic [ADDR_W-1:0] jump_addr_o,
   output logic [FLAG_W-1:0] flags_restore_o,
   output logic in_handler_o
);
   logic [NUM_IRQ-1:0] evt_meta_ff;
   logic [NUM_IRQ-1:0] evt_sync_ff;
   logic [NUM_IRQ-1:0] evt_prev_ff;
   logic [NUM_IRQ-1:0] pend_ff;
   logic [NUM_IRQ-1:0] enable_ff;
   logic [NUM_IRQ-1:0] handler_address_cmd_ok_ff;
   logic [ADDR_W-1:0] handler_address_cmd_ff [NUM_IRQ];
   logic global_en_ff;
   logic [DATA_W-1:0] accu_ff;
   logic [DATA_W-1:0] xreg_ff;
   logic [DATA_W-1:0] save_accu_ff;
   logic [DATA_W-1:0] save_xreg_ff;
   logic [FLAG_W-1:0] save_flags_ff;
   logic [ADDR_W-1:0] save_pc_ff;
   sid_state_t state_ff;
   logic [NUM_IRQ-1:0] evt_raw;
   logic [NUM_IRQ-1:0] ready;
   logic take;
   logic [IRQ_W-1:0] sel;
   logic prog_cmd;
   logic ret_cmd;
   logic [DATA_W-1:0] nxt_accu;

   function automatic logic is_cmd(input logic [7:0] num, input logic [7:0] code);
      is_cmd = cmd_valid_i && (num == code);
   endfunction : is_cmd

   function automatic logic [DATA_W-1:0] accu_const_arith_cmd(input logic [7:0] op, input logic [DATA_W-1:0] a,
                                              input logic [DATA_W-1:0] b);
      case (op)
         OP_ADD: accu_const_arith_cmd = a + b;
         OP_SUB: accu_const_arith_cmd = a - b;
         OP_MUL: accu_const_arith_cmd = DATA_W'(a * b);
         OP_AND: accu_const_arith_cmd = a & b;
         OP_OR: accu_const_arith_cmd = a | b;
         OP_XOR: accu_const_arith_cmd = a ^ b;
         OP_NOT: accu_const_arith_cmd = ~a;
         OP_LOAD: accu_const_arith_cmd = b;
         default: accu_const_arith_cmd = a;
      endcase
   endfunction : accu_const_arith_cmd

   assign evt_raw[2:0] = timer_evt_i;
   assign evt_raw[8:3] = reached_evt_i;
   assign evt_raw[14:9] = 6'h00;
   assign evt_raw[20:15] = stall_evt_i;
   assign evt_raw[26:21] = deviation_evt_i;
   assign evt_raw[38:27] = stop_switch_evt_i;
   assign evt_raw[42:39] = input_change_evt_i;

   assign prog_cmd = cmd_valid_i && !cmd_direct_i;
   assign ret_cmd = prog_cmd && (cmd_num_i == CMD_HANDLER_RETURN) && (state_ff == SID_HANDLER);

   assign ready = pend_ff & enable_ff & handler_address_cmd_ok_ff;
   assign take = global_en_ff && (state_ff == SID_NORMAL) && (|ready) && !prog_cmd;

   always_comb
   begin
      sel = '0;
      for (int i = NUM_IRQ - 1; i >= 0; i--)
      begin
         if (ready[i])
         begin
            sel = IRQ_W'(i);
         end
      end
   end

   // pin events: two-stage sync, edge detect
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         evt_meta_ff <= '0;
         evt_sync_ff <= '0;
         evt_prev_ff <= '0;
      end
      else
      begin
         evt_meta_ff <= evt_raw;
         evt_sync_ff <= evt_meta_ff;
         evt_prev_ff <= evt_sync_ff;
      end
   end

   // pending flags; a new edge wins over the clear on dispatch
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pend_ff <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_IRQ; i++)
         begin
            if (evt_sync_ff[i] && !evt_prev_ff[i])
            begin
               pend_ff[i] <= 1'b1;
            end
            else if (take && sel == IRQ_W'(i))
            begin
               pend_ff[i] <= 1'b0;
            end
            // global switch off drops it too, no stale dispatch later
            else if (!enable_ff[i] || !handler_address_cmd_ok_ff[i] || !global_en_ff)
            begin
               pend_ff[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         enable_ff <= '0;
         handler_address_cmd_ok_ff <= '0;
         global_en_ff <= 1'b0;
         for (int i = 0; i < NUM_IRQ; i++)
         begin
            handler_address_cmd_ff[i] <= ADDR_RESET;
         end
      end
      else if (cmd_valid_i)
      begin
         if (cmd_num_i == CMD_UNMASK_INTERRUPT || cmd_num_i == CMD_MASK_INTERRUPT)
         begin
            if (cmd_type_i == IRQ_GLOBAL)
            begin
               global_en_ff <= (cmd_num_i == CMD_UNMASK_INTERRUPT);
            end
            else if (cmd_type_i < 8'(NUM_IRQ))
            begin
               enable_ff[cmd_type_i[IRQ_W-1:0]] <= (cmd_num_i == CMD_UNMASK_INTERRUPT);
            end
         end
         else if (cmd_num_i == CMD_HANDLER_ADDRESS && cmd_type_i < 8'(NUM_IRQ))
         begin
            handler_address_cmd_ff[cmd_type_i[IRQ_W-1:0]] <= cmd_value_i[ADDR_W-1:0];
            handler_address_cmd_ok_ff[cmd_type_i[IRQ_W-1:0]] <= 1'b1;
         end
      end
   end

   // accumulator next value; direct mode never reaches here
   always_comb
   begin
      nxt_accu = accu_ff;
      if (prog_cmd)
      begin
         if (cmd_num_i == CMD_ACCU_CONST_ARITH)
         begin
            nxt_accu = accu_const_arith_cmd(cmd_type_i, accu_ff, cmd_value_i);
         end
         else if (cmd_num_i == CMD_ACCU_XREG_ARITH)
         begin
            nxt_accu = accu_const_arith_cmd(cmd_type_i, accu_ff, xreg_ff);
         end
         else if (cmd_num_i == CMD_READ_INPUT || cmd_num_i == CMD_GET_AXIS_PARAM ||
                  cmd_num_i == CMD_GET_GLOBAL_PARAM)
         begin
            nxt_accu = read_data_i;
         end
      end
   end

   // state, context save and restore
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_ff <= SID_NORMAL;
         accu_ff <= ACCU_RESET;
         xreg_ff <= ACCU_RESET;
         save_accu_ff <= ACCU_RESET;
         save_xreg_ff <= ACCU_RESET;
         save_flags_ff <= '0;
         save_pc_ff <= ADDR_RESET;
         jump_o <= 1'b0;
         jump_addr_o <= ADDR_RESET;
         flags_restore_o <= '0;
      end
      else
      begin
         jump_o <= 1'b0;
         case (state_ff)
            SID_NORMAL:
            begin
               accu_ff <= nxt_accu;
               if (prog_cmd && cmd_num_i == CMD_ACCU_XREG_ARITH && cmd_type_i == OP_TO_XREG)
               begin
                  xreg_ff <= accu_ff;
                  accu_ff <= accu_ff;
               end
               if (take)
               begin
                  save_accu_ff <= accu_ff;
                  save_xreg_ff <= xreg_ff;
                  save_flags_ff <= flags_i;
                  save_pc_ff <= pc_i;
                  jump_o <= 1'b1;
                  jump_addr_o <= handler_address_cmd_ff[sel];
                  state_ff <= SID_HANDLER;
               end
            end
            SID_HANDLER:
            begin
               accu_ff <= nxt_accu;
               if (prog_cmd && cmd_num_i == CMD_ACCU_XREG_ARITH && cmd_type_i == OP_TO_XREG)
               begin
                  xreg_ff <= accu_ff;
                  accu_ff <= accu_ff;
               end
               // relies on handler ending in return
               if (ret_cmd)
               begin
                  accu_ff <= save_accu_ff;
                  xreg_ff <= save_xreg_ff;
                  flags_restore_o <= save_flags_ff;
                  jump_o <= 1'b1;
                  jump_addr_o <= save_pc_ff;
                  state_ff <= SID_NORMAL;
               end
            end
            default:
            begin
               state_ff <= SID_NORMAL;
            end
         endcase
      end
   end

   // strobes, host replies, config
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         write_output_o <= 1'b0;
         read_input_o <= 1'b0;
         accu_to_axis_param_o <= 1'b0;
         accu_to_global_param_o <= 1'b0;
         accu_to_coord_o <= 1'b0;
         irq_config_o <= 1'b0;
         irq_config_num_o <= '0;
         irq_config_value_o <= ACCU_RESET;
         reply_valid_o <= 1'b0;
         reply_data_o <= ACCU_RESET;
      end
      else
      begin
         write_output_o <= is_cmd(cmd_num_i, CMD_WRITE_OUTPUT);
         read_input_o <= is_cmd(cmd_num_i, CMD_READ_INPUT);
         accu_to_axis_param_o <= is_cmd(cmd_num_i, CMD_ACCU_TO_AXIS_PARAM);
         accu_to_global_param_o <= is_cmd(cmd_num_i, CMD_ACCU_TO_GLOBAL_PARAM);
         accu_to_coord_o <= is_cmd(cmd_num_i, CMD_ACCU_TO_COORD);
         irq_config_o <= is_cmd(cmd_num_i, CMD_SET_GLOBAL_PARAM) && cmd_bank_i == IRQ_CONFIG_BANK &&
                         cmd_type_i < 8'(NUM_IRQ);
         irq_config_num_o <= cmd_type_i[IRQ_W-1:0];
         irq_config_value_o <= cmd_value_i;
         reply_valid_o <= cmd_valid_i && cmd_direct_i;
         reply_data_o <= read_data_i;
      end
   end

   assign accu_o = accu_ff;
   assign xreg_o = xreg_ff;
   // one-hot handler bit, straight from the state flop
   assign in_handler_o = state_ff[1];
endmodule : sid_dispatch
`default_nettype wire

// file: src/sid_pkg.sv
// package: command numbers, interrupt numbering, widths and reset values
// assumes one system clock; used by sid_dispatch, its monitor and its bench
package sid_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned NUM_IRQ = 43;
   localparam int unsigned IRQ_W = 6;
   localparam int unsigned FLAG_W = 4;
   // command numbers
   localparam logic [7:0] CMD_WRITE_OUTPUT = 8'h0e;
   localparam logic [7:0] CMD_READ_INPUT = 8'h0f;
   localparam logic [7:0] CMD_SET_GLOBAL_PARAM = 8'h09;
   localparam logic [7:0] CMD_GET_AXIS_PARAM = 8'h06;
   localparam logic [7:0] CMD_GET_GLOBAL_PARAM = 8'h0a;
   localparam logic [7:0] CMD_ACCU_CONST_ARITH = 8'h13;
   localparam logic [7:0] CMD_UNMASK_INTERRUPT = 8'h19;
   localparam logic [7:0] CMD_MASK_INTERRUPT = 8'h1a;
   localparam logic [7:0] CMD_ACCU_XREG_ARITH = 8'h21;
   localparam logic [7:0] CMD_ACCU_TO_AXIS_PARAM = 8'h22;
   localparam logic [7:0] CMD_ACCU_TO_GLOBAL_PARAM = 8'h23;
   localparam logic [7:0] CMD_HANDLER_ADDRESS = 8'h25;
   localparam logic [7:0] CMD_HANDLER_RETURN = 8'h26;
   localparam logic [7:0] CMD_ACCU_TO_COORD = 8'h27;
   // interrupt numbering
   localparam logic [7:0] IRQ_TIMER_BASE = 8'h00;
   localparam logic [7:0] IRQ_POS_REACHED_BASE = 8'h03;
   localparam logic [7:0] IRQ_STALL_BASE = 8'h0f;
   localparam logic [7:0] IRQ_DEVIATION_BASE = 8'h15;
   localparam logic [7:0] IRQ_STOP_SWITCH_BASE = 8'h1b;
   localparam logic [7:0] IRQ_INPUT_CHANGE_BASE = 8'h27;
   localparam logic [7:0] IRQ_GLOBAL = 8'hff;
   localparam logic [7:0] IRQ_CONFIG_BANK = 8'h03;
   // accu_const_arith_cmd operations (operation type field)
   localparam logic [7:0] OP_ADD = 8'h00;
   localparam logic [7:0] OP_SUB = 8'h01;
   localparam logic [7:0] OP_MUL = 8'h02;
   localparam logic [7:0] OP_AND = 8'h04;
   localparam logic [7:0] OP_OR = 8'h05;
   localparam logic [7:0] OP_XOR = 8'h06;
   localparam logic [7:0] OP_NOT = 8'h07;
   localparam logic [7:0] OP_LOAD = 8'h08;
   localparam logic [7:0] OP_TO_XREG = 8'h01;
   localparam logic [DATA_W-1:0] ACCU_RESET = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
   typedef enum logic [1:0]
   {
      SID_NORMAL = 2'b01,
      SID_HANDLER = 2'b10
   } sid_state_t;
endpackage : sid_pkg

// file: verification/sid_dispatch_monitor.sv
// checker: port timing of sid_dispatch
// assumes bind to sid_dispatch, one clock domain
`timescale 1ns/100ps
`default_nettype none
module sid_dispatch_monitor
   import sid_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_direct_i,
   input wire logic [7:0] cmd_num_i,
   input wire logic [7:0] cmd_type_i,
   input wire logic [7:0] cmd_bank_i,
   input wire logic [DATA_W-1:0] cmd_value_i,
   input wire logic [DATA_W-1:0] read_data_i,
   input wire logic write_output_o,
   input wire logic accu_to_axis_param_o,
   input wire logic irq_config_o,
   input wire logic [IRQ_W-1:0] irq_config_num_o,
   input wire logic [DATA_W-1:0] irq_config_value_o,
   input wire logic [DATA_W-1:0] accu_o,
   input wire logic [DATA_W-1:0] xreg_o,
   input wire logic reply_valid_o,
   input wire logic [DATA_W-1:0] reply_data_o,
   input wire logic jump_o,
   input wire logic in_handler_o
);
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   wire logic prog = cmd_valid_i && !cmd_direct_i;
   wire logic ret = prog && cmd_num_i == CMD_HANDLER_RETURN;
   sequence s_ret;
      ret && in_handler_o;
   endsequence
   sequence s_back;
      jump_o && !in_handler_o;
   endsequence
   property p_out;
      cmd_valid_i && cmd_num_i == CMD_WRITE_OUTPUT |=> write_output_o;
   endproperty
   a_out: assert property (p_out) else $error("no output strobe");
   property p_axis;
      cmd_valid_i && cmd_num_i == CMD_ACCU_TO_AXIS_PARAM |=> accu_to_axis_param_o;
   endproperty
   a_axis: assert property (p_axis) else $error("no axis copy strobe");
   property p_read;
      prog && cmd_num_i == CMD_GET_GLOBAL_PARAM |=> accu_o == $past(read_data_i);
   endproperty
   a_read: assert property (p_read) else $error("read not in accumulator");
   property p_xload;
      prog && cmd_num_i == CMD_ACCU_XREG_ARITH && cmd_type_i == OP_TO_XREG && !$past(prog) |=> xreg_o == $past(accu_o);
   endproperty
   a_xload: assert property (p_xload) else $error("x register not loaded");
   property p_direct;
      cmd_valid_i && cmd_direct_i && !$past(prog) |=> $stable(accu_o);
   endproperty
   a_direct: assert property (p_direct) else $error("direct command moved accumulator");
   property p_reply;
      cmd_valid_i && cmd_direct_i |=> reply_valid_o && reply_data_o == $past(read_data_i);
   endproperty
   a_reply: assert property (p_reply) else $error("host reply wrong");
   property p_cfg;
      cmd_valid_i && cmd_num_i == CMD_SET_GLOBAL_PARAM && cmd_bank_i == IRQ_CONFIG_BANK && cmd_type_i < 8'h2b
      |=> irq_config_o && irq_config_num_o == $past(cmd_type_i[5:0]) && irq_config_value_o == $past(cmd_value_i);
   endproperty
   a_cfg: assert property (p_cfg) else $error("interrupt config not forwarded");
   property p_nest;
      $past(in_handler_o) && !$past(ret) |-> !jump_o;
   endproperty
   a_nest: assert property (p_nest) else $error("jump inside handler");
   property p_ret;
      s_ret |=> s_back;
   endproperty
   a_ret: assert property (p_ret) else $error("return did not resume");
endmodule : sid_dispatch_monitor
bind sid_dispatch sid_dispatch_monitor sid_dispatch_monitor_i (.*);
`default_nettype wire

// file: verification/sid_host_model.sv
// host model: puts commands on the command path
// assumes bench sets request fields; outputs move after clock edges
`timescale 1ns/100ps
`default_nettype none
module sid_host_model
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic req_i,
   input wire logic dir_i,
   input wire logic [7:0] num_i,
   input wire logic [7:0] typ_i,
   input wire logic [7:0] bank_i,
   input wire logic [31:0] val_i,
   output logic cmd_valid_o,
   output logic cmd_direct_o,
   output logic [7:0] cmd_num_o,
   output logic [7:0] cmd_type_o,
   output logic [7:0] cmd_bank_o,
   output logic [31:0] cmd_value_o
);
   // idle fields toggle so stale values are never trusted
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cmd_valid_o <= 1'b0;
         {cmd_direct_o, cmd_num_o, cmd_type_o, cmd_bank_o, cmd_value_o} <= '0;
      end
      else
      begin
         cmd_valid_o <= req_i;
         cmd_direct_o <= req_i ? dir_i : ~cmd_direct_o;
         cmd_num_o <= req_i ? num_i : ~cmd_num_o;
         cmd_type_o <= req_i ? typ_i : ~cmd_type_o;
         cmd_bank_o <= req_i ? bank_i : ~cmd_bank_o;
         cmd_value_o <= req_i ? val_i : ~cmd_value_o;
      end
   end
endmodule : sid_host_model
`default_nettype wire

// file: verification/sid_dispatch_test.sv
// bench for sid_dispatch: decode, accumulator, dispatch and return
// assumes sid_pkg, host model and monitor bind; clock 25 MHz
`timescale 1ns/100ps
`default_nettype none
module sid_dispatch_test
   import sid_pkg::*;
();
   logic clock_i = 0, nrst_i = 0, req = 0, dir = 0;
   logic [7:0] num = 0, typ = 0, bank = 0;
   logic [31:0] val = 0, rd = 0;
   logic [15:0] pc = 0;
   logic [3:0] flg = 0, inc = 0;
   logic [2:0] tmr = 0;
   logic [5:0] rch = 0, stl = 0, dev = 0;
   logic [11:0] sw = 0;
   logic cv, cd, wo, ri, accu_to_axis_param_cmd, accu_to_global_param_cmd, accu_to_coord_cmd, icfg, rv, jmp, inh;
   logic [7:0] cn, ct, cb;
   logic [5:0] icn;
   logic [31:0] cval, icv, accu, xreg, rdat;
   logic [15:0] ja;
   logic [3:0] frs;
   logic [7:0] ops [5] = '{CMD_WRITE_OUTPUT, CMD_READ_INPUT, CMD_ACCU_TO_AXIS_PARAM, CMD_ACCU_TO_GLOBAL_PARAM, CMD_ACCU_TO_COORD};
   int error_cnt = 0, total_checks = 0, cyc = 0;
   sid_host_model sid_host_model_i (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req), .dir_i(dir), .num_i(num),
      .typ_i(typ), .bank_i(bank), .val_i(val), .cmd_valid_o(cv), .cmd_direct_o(cd), .cmd_num_o(cn),
      .cmd_type_o(ct), .cmd_bank_o(cb), .cmd_value_o(cval));
   sid_dispatch sid_dispatch_i (.clock_i(clock_i), .nrst_i(nrst_i), .cmd_valid_i(cv), .cmd_direct_i(cd),
      .cmd_num_i(cn), .cmd_type_i(ct), .cmd_bank_i(cb), .cmd_value_i(cval), .read_data_i(rd), .pc_i(pc),
      .flags_i(flg), .timer_evt_i(tmr), .reached_evt_i(rch), .stall_evt_i(stl), .deviation_evt_i(dev),
      .stop_switch_evt_i(sw), .input_change_evt_i(inc), .write_output_o(wo), .read_input_o(ri),
      .accu_to_axis_param_o(accu_to_axis_param_cmd), .accu_to_global_param_o(accu_to_global_param_cmd), .accu_to_coord_o(accu_to_coord_cmd), .irq_config_o(icfg),
      .irq_config_num_o(icn), .irq_config_value_o(icv), .accu_o(accu), .xreg_o(xreg), .reply_valid_o(rv),
      .reply_data_o(rdat), .jump_o(jmp), .jump_addr_o(ja), .flags_restore_o(frs), .in_handler_o(inh));
   initial
   begin
      forever #20 clock_i = ~clock_i;
   end
   task results;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk
   task cmd(input logic d, input logic [7:0] n, input logic [7:0] t, input logic [7:0] b, input logic [31:0] v);
      @(posedge clock_i);
      #1 {req, dir, num, typ, bank, val} = {1'b1, d, n, t, b, v};
      @(posedge clock_i);
      #1 req = 0;
      @(posedge clock_i);
      #1;
   endtask : cmd
   task want_jump(input logic [15:0] a);
      int k;
      k = 0;
      // a jump standing now belongs to the step before
      @(posedge clock_i);
      #1;
      while (jmp !== 1'b1 && k < 20)
      begin
         @(posedge clock_i);
         #1 k++;
      end
      chk(32'(jmp), 1);
      chk(32'(ja), 32'(a));
   endtask : want_jump
   task no_jump;
      int n;
      n = 0;
      repeat (12)
      begin
         @(posedge clock_i);
         #1 if (jmp !== 1'b0) n++;
      end
      chk(n, 0);
   endtask : no_jump
   task t_decode;
      for (int d = 0; d < 2; d++)
      begin
         for (int i = 0; i < 5; i++)
         begin
            cmd(d[0], ops[i], 0, 0, 0);
            chk(32'({wo, ri, accu_to_axis_param_cmd, accu_to_global_param_cmd, accu_to_coord_cmd}), 32'h10 >> i);
         end
      end
   endtask : t_decode
   task t_accu;
      rd = 32'h1234_5678;
      cmd(0, CMD_GET_GLOBAL_PARAM, 0, 0, 0);
      chk(accu, 32'h1234_5678);
      cmd(0, CMD_ACCU_XREG_ARITH, OP_TO_XREG, 0, 0);
      chk(xreg, 32'h1234_5678);
      cmd(0, CMD_ACCU_CONST_ARITH, OP_ADD, 0, 32'h5);
      chk(accu, 32'h1234_567d);
      rd = 32'h0bad_f00d;
      cmd(1, CMD_GET_AXIS_PARAM, 0, 0, 0);
      chk(accu, 32'h1234_567d);
      chk(32'(rv), 32'h1);
      chk(rdat, 32'h0bad_f00d);
      cmd(0, CMD_SET_GLOBAL_PARAM, 8'h2a, IRQ_CONFIG_BANK, 32'h3e8);
      chk(32'({icfg, icn}), 32'h6a);
      chk(icv, 32'h3e8);
   endtask : t_accu
   task t_irq;
      pc = 16'h0123;
      flg = 4'ha;
      cmd(0, CMD_HANDLER_ADDRESS, IRQ_POS_REACHED_BASE, 0, 32'ha00);
      cmd(0, CMD_HANDLER_ADDRESS, IRQ_STALL_BASE, 0, 32'hb00);
      cmd(0, CMD_UNMASK_INTERRUPT, IRQ_POS_REACHED_BASE, 0, 0);
      cmd(0, CMD_UNMASK_INTERRUPT, IRQ_STALL_BASE, 0, 0);
      cmd(0, CMD_UNMASK_INTERRUPT, IRQ_TIMER_BASE, 0, 0);
      rch[0] = 1;
      no_jump();
      rch[0] = 0;
      cmd(0, CMD_UNMASK_INTERRUPT, IRQ_GLOBAL, 0, 0);
      tmr[0] = 1;
      no_jump();
      {rch[0], stl[0]} = 2'b11;
      want_jump(16'ha00);
      no_jump();
      chk(32'(inh), 1);
      rd = 32'h5555;
      cmd(0, CMD_GET_GLOBAL_PARAM, 0, 0, 0);
      cmd(0, CMD_ACCU_XREG_ARITH, OP_TO_XREG, 0, 0);
      cmd(0, CMD_HANDLER_RETURN, 0, 0, 0);
      chk(32'({jmp, ja}), 32'h1_0123);
      chk(accu, 32'h1234_567d);
      chk(xreg, 32'h1234_5678);
      chk(32'(frs), 32'ha);
      want_jump(16'hb00);
      cmd(0, CMD_HANDLER_RETURN, 0, 0, 0);
      chk(32'(inh), 0);
      cmd(0, CMD_MASK_INTERRUPT, IRQ_STALL_BASE, 0, 0);
      stl[0] = 0;
      repeat (4) @(posedge clock_i);
      #1 stl[0] = 1;
      no_jump();
      cmd(0, CMD_HANDLER_ADDRESS, IRQ_STOP_SWITCH_BASE + 8'h01, 0, 32'hc00);
      cmd(0, CMD_UNMASK_INTERRUPT, IRQ_STOP_SWITCH_BASE + 8'h01, 0, 0);
      sw[1] = 1;
      want_jump(16'hc00);
      cmd(0, CMD_HANDLER_RETURN, 0, 0, 0);
      chk(32'(inh), 0);
   endtask : t_irq
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         results();
      end
   end
   initial
   begin
      repeat (16) @(posedge clock_i);
      #1 nrst_i = 1;
      t_decode();
      t_accu();
      t_irq();
      results();
   end
endmodule : sid_dispatch_test
`default_nettype wire
